// ===== core/ptmr_timer.v
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "ptmr_regs.vh"

module ptmr_timer
(
  // Clock and reset.
  input wire core_clk,
  input wire rst_n,
  // Timer count tick from an upstream clock selector, same domain.
  input wire tick,
  // Register port.
  input wire [`PTMR_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Output pin.
  output reg pin_out,
  output reg pin_oe
);

  reg [7:0] ctrl0_reg;
  reg [7:0] ctrl1_reg;
  reg [15:0] duty_reg;
  reg [15:0] per_reg;
  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg en_d_reg;
  reg aflag_reg;
  reg pflag_reg;
  reg cmp_lvl_reg;
  reg pwm_on_reg;
  reg pwm_on_next;
  reg cmp_lvl_next;
  reg set_a;
  reg set_p;

  wire [1:0] mode = ctrl1_reg[`PTMR_C1_MODE_HI:`PTMR_C1_MODE_LO];
  wire [1:0] pinf = ctrl1_reg[`PTMR_C1_PIN_HI:`PTMR_C1_PIN_LO];
  wire enable = ctrl0_reg[`PTMR_C0_ENABLE];
  wire en_rise = enable & ~en_d_reg;
  // Pause only masks ticks, so the count holds and resumes from where it stopped.
  wire run = enable & ~ctrl0_reg[`PTMR_C0_PAUSE] & tick;
  wire is_pwm = (mode == `PTMR_MODE_PWM);
  wire is_cmp = (mode == `PTMR_MODE_CMP) | (mode == `PTMR_MODE_TMR);
  wire [15:0] cnt_inc = cnt_reg + 16'h0001;
  // Matches are judged on the value the counter takes after this tick.
  wire a_hit = (cnt_inc == duty_reg) & (duty_reg != `PTMR_RESET_WORD);
  wire p_hit = (cnt_inc == per_reg) & (per_reg != `PTMR_RESET_WORD);
  wire ovf = (cnt_reg == `PTMR_MAX_COUNT);
  wire clr_write = reg_wr & (reg_addr == `PTMR_OFF_CTRL0);

  //////////////////////////////////////////////////////////////////////////////
  // Counter and match decisions.
  always @*
  begin
    cnt_next = cnt_reg;
    set_a = 1'b0;
    set_p = 1'b0;
    cmp_lvl_next = cmp_lvl_reg;
    pwm_on_next = pwm_on_reg;
    if (en_rise)
    begin
      cnt_next = `PTMR_RESET_WORD;
      cmp_lvl_next = ctrl1_reg[`PTMR_C1_INIT];
      pwm_on_next = 1'b1;
    end
    else if (run)
    begin
      cnt_next = cnt_inc;
      if (is_pwm)
      begin
        // The counter keeps running whatever the pin field forces.
        set_a = a_hit;
        set_p = p_hit | ((per_reg == `PTMR_RESET_WORD) & ovf);
        if (set_p)
        begin
          cnt_next = `PTMR_RESET_WORD;
          pwm_on_next = 1'b1;
        end
        if (a_hit & ~set_p)
          pwm_on_next = 1'b0;
      end
      else if (ctrl1_reg[`PTMR_C1_CLRSEL])
      begin
        set_a = a_hit;
        if (a_hit)
          cnt_next = `PTMR_RESET_WORD;
      end
      else
      begin
        set_a = a_hit;
        set_p = p_hit;
        if (p_hit)
          cnt_next = `PTMR_RESET_WORD;
      end
      // Pin moves only on an A flag; P matches leave it alone.
      if (is_cmp & set_a)
      begin
        case (pinf)
          `PTMR_PIN_LOW: cmp_lvl_next = 1'b0;
          `PTMR_PIN_HIGH: cmp_lvl_next = 1'b1;
          `PTMR_PIN_TOGGLE: cmp_lvl_next = ~cmp_lvl_reg;
          default: cmp_lvl_next = cmp_lvl_reg;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers, flags and pin.
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ctrl0_reg <= `PTMR_RESET_BYTE;
      ctrl1_reg <= `PTMR_RESET_BYTE;
      duty_reg <= `PTMR_RESET_WORD;
      per_reg <= `PTMR_RESET_WORD;
      cnt_reg <= `PTMR_RESET_WORD;
      en_d_reg <= 1'b0;
      aflag_reg <= 1'b0;
      pflag_reg <= 1'b0;
      cmp_lvl_reg <= 1'b0;
      pwm_on_reg <= 1'b0;
      reg_rdata <= `PTMR_RESET_BYTE;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else
    begin
      en_d_reg <= enable;
      cnt_reg <= cnt_next;
      cmp_lvl_reg <= cmp_lvl_next;
      pwm_on_reg <= pwm_on_next;
      // Flags clear by writing one; a match in the same cycle wins.
      aflag_reg <= set_a | (aflag_reg & ~(clr_write & reg_wdata[`PTMR_C0_AFLAG]));
      pflag_reg <= set_p | (pflag_reg & ~(clr_write & reg_wdata[`PTMR_C0_PFLAG]));
      if (reg_wr)
      begin
        case (reg_addr)
          `PTMR_OFF_CTRL0: ctrl0_reg <= {reg_wdata[7:3], 3'h0};
          `PTMR_OFF_CTRL1: ctrl1_reg <= reg_wdata;
          `PTMR_OFF_DUTY_LO: duty_reg[7:0] <= reg_wdata;
          `PTMR_OFF_DUTY_HI: duty_reg[15:8] <= reg_wdata;
          `PTMR_OFF_PER_LO: per_reg[7:0] <= reg_wdata;
          `PTMR_OFF_PER_HI: per_reg[15:8] <= reg_wdata;
          default: ;
        endcase
      end
      // Read data stands only in the cycle after the strobe.
      if (reg_rd)
      begin
        case (reg_addr)
          `PTMR_OFF_CTRL0: reg_rdata <= {ctrl0_reg[7:3], 1'b0, aflag_reg, pflag_reg};
          `PTMR_OFF_CTRL1: reg_rdata <= ctrl1_reg;
          `PTMR_OFF_CNT_LO: reg_rdata <= cnt_reg[7:0];
          `PTMR_OFF_CNT_HI: reg_rdata <= cnt_reg[15:8];
          `PTMR_OFF_DUTY_LO: reg_rdata <= duty_reg[7:0];
          `PTMR_OFF_DUTY_HI: reg_rdata <= duty_reg[15:8];
          `PTMR_OFF_PER_LO: reg_rdata <= per_reg[7:0];
          default: reg_rdata <= per_reg[15:8];
        endcase
      end
      else
        reg_rdata <= `PTMR_RESET_BYTE;
      // Pin driver: timer/counter mode releases the pin to other functions.
      pin_oe <= (mode != `PTMR_MODE_TMR);
      if (is_pwm)
      begin
        case (pinf)
          `PTMR_PWM_FORCE_OFF: pin_out <= ~ctrl1_reg[`PTMR_C1_INIT] ^ ctrl1_reg[`PTMR_C1_INV];
          `PTMR_PWM_FORCE_ON: pin_out <= ctrl1_reg[`PTMR_C1_INIT] ^ ctrl1_reg[`PTMR_C1_INV];
          default: pin_out <= (pwm_on_next ~^ ctrl1_reg[`PTMR_C1_INIT]) ^
            ctrl1_reg[`PTMR_C1_INV];
        endcase
      end
      else
        pin_out <= cmp_lvl_next ^ ctrl1_reg[`PTMR_C1_INV];
    end
  end

endmodule // ptmr_timer

// ===== core/ptmr_regs.vh
`ifndef PTMR_REGS_VH
`define PTMR_REGS_VH
`define PTMR_ADDR_W 3
`define PTMR_OFF_CTRL0 3'h0
`define PTMR_OFF_CTRL1 3'h1
`define PTMR_OFF_CNT_LO 3'h2
`define PTMR_OFF_CNT_HI 3'h3
`define PTMR_OFF_DUTY_LO 3'h4
`define PTMR_OFF_DUTY_HI 3'h5
`define PTMR_OFF_PER_LO 3'h6
`define PTMR_OFF_PER_HI 3'h7
`define PTMR_C0_PAUSE 7
`define PTMR_C0_ENABLE 3
`define PTMR_C0_AFLAG 1
`define PTMR_C0_PFLAG 0
`define PTMR_C1_MODE_HI 7
`define PTMR_C1_MODE_LO 6
`define PTMR_C1_PIN_HI 5
`define PTMR_C1_PIN_LO 4
`define PTMR_C1_INIT 3
`define PTMR_C1_INV 2
`define PTMR_C1_CLRSEL 0
`define PTMR_MODE_CMP 2'h0
`define PTMR_MODE_PWM 2'h2
`define PTMR_MODE_TMR 2'h3
`define PTMR_PIN_NONE 2'h0
`define PTMR_PIN_LOW 2'h1
`define PTMR_PIN_HIGH 2'h2
`define PTMR_PIN_TOGGLE 2'h3
`define PTMR_PWM_FORCE_OFF 2'h0
`define PTMR_PWM_FORCE_ON 2'h1
`define PTMR_PWM_RUN 2'h2
`define PTMR_RESET_BYTE 8'h00
`define PTMR_RESET_WORD 16'h0000
`define PTMR_MAX_COUNT 16'hffff
`endif

// ===== tb/ptmr_sva.sv
`timescale 1ns/1ps
// Checks pin and readback behaviour against shadows of the written control, duty and period bytes.
module ptmr_sva (
  // Clock and reset.
  input wire core_clk,
  input wire rst_n,
  // Tick and register port.
  input wire tick,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Output pin.
  input wire pin_out,
  input wire pin_oe
);
  logic [7:0] c1_q;
  logic [7:0] sh_q [4];
  logic en_q;
  wire [1:0] md = c1_q[7:6];
  wire pw = c1_q[7:4] == 4'ha;
  wire lvl = c1_q[3] ^ c1_q[2];
  wire [7:0] rd_exp = sh_q[reg_addr[1:0]];
  wire en_rise = reg_wr && reg_addr == 3'h0 && reg_wdata[3] && !en_q && md == 2'h0;
  // Shadows keep expectations independent of what the design reads back.
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      c1_q <= 8'h00;
      en_q <= 1'b0;
      sh_q <= '{4{8'h00}};
    end
    else if (reg_wr)
    begin
      if (reg_addr == 3'h0) en_q <= reg_wdata[3];
      if (reg_addr == 3'h1) c1_q <= reg_wdata;
      if (reg_addr[2]) sh_q[reg_addr[1:0]] <= reg_wdata;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // The load happens one edge after the enable write and wins over a tick at that edge.
  sequence s_en;
    en_rise ##1 !tick;
  endsequence
  a_duty_read:
    assert property (reg_rd && reg_addr[2:1] == 2'h2 |=> reg_rdata == $past(rd_exp))
    else $error("duty readback");
  a_per_read:
    assert property (reg_rd && reg_addr[2:1] == 2'h3 |=> reg_rdata == $past(rd_exp))
    else $error("period readback");
  a_cmp_drive:
    assert property ($past(rst_n) && md == 2'h0 && $past(md) == 2'h0 |-> pin_oe)
    else $error("compare pin released");
  a_tmr_release:
    assert property ($past(rst_n) && md == 2'h3 && $past(md) == 2'h3 |-> !pin_oe)
    else $error("timer pin driven");
  a_pwm_drive:
    assert property ($past(rst_n) && pw && $past(pw) |-> pin_oe)
    else $error("pwm pin released");
  a_pin_quiet:
    assert property (md == 2'h0 && !$past(tick) && !$past(reg_wr) && !$past(reg_wr, 2)
      |-> $stable(pin_out)) else $error("pin moved without tick");
  a_enable_init:
    assert property (s_en |=> pin_out == lvl) else $error("initial level");
  a_pwm_force:
    assert property (md == 2'h2 && !c1_q[5] && !$past(reg_wr) && !$past(reg_wr, 2)
      |-> pin_out == (lvl ^ !c1_q[4])) else $error("forced level");
endmodule // ptmr_sva
bind ptmr_timer ptmr_sva u_sva (.core_clk, .rst_n, .tick, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .pin_out, .pin_oe);

// ===== tb/ptmr_pin_load.sv
`timescale 1ns/1ps
// Load on the pin; a weak pull-down sets the line while the timer releases it.
module ptmr_pin_load (
  // Pin from the timer.
  input wire pin_out,
  input wire pin_oe,
  // Line level and count of its rising edges.
  output wire pin_line,
  output logic [7:0] rises
);
  assign pin_line = pin_oe ? pin_out : 1'b0;
  initial rises = 8'h00;
  // Counted on the line itself, so the count is current as soon as the edge lands.
  always @(posedge pin_line) rises <= rises + 8'h01;
endmodule // ptmr_pin_load

// ===== tb/ptmr_timer_bench.sv
`timescale 1ns/1ps
module ptmr_timer_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic tick = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] r0;
  wire [7:0] reg_rdata;
  wire [7:0] rises;
  wire pin_out;
  wire pin_oe;
  wire pin_line;
  int err_count = 0;
  int checked = 0;
  always #2.5 core_clk = ~core_clk;
  ptmr_timer u_dut (.core_clk, .rst_n, .tick, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pin_out, .pin_oe);
  ptmr_pin_load u_load (.pin_out, .pin_oe, .pin_line, .rises);
  task chk(input logic [7:0] s, input logic [7:0] e);
  begin
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  end
  endtask
  // Single-cycle strobes; the gap cycle keeps a strobe from being set twice in one step.
  task wr(input logic [2:0] a, input logic [7:0] d);
  begin
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
  begin
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, e);
  end
  endtask
  task tk(input int n);
  begin
    repeat (n)
    begin
      @(posedge core_clk);
      tick <= 1'b1;
    end
    @(posedge core_clk);
    tick <= 1'b0;
  end
  endtask
  // The pin is registered, so one more edge passes before it is looked at.
  task pk(input logic e);
  begin
    @(posedge core_clk);
    @(negedge core_clk);
    chk({7'h00, pin_out}, {7'h00, e});
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 4; i < 8; i++) rd(i[2:0], 8'h00);
    wr(3'h1, 8'h30);
    wr(3'h4, 8'h02);
    wr(3'h6, 8'h03);
    wr(3'h0, 8'h08);
    tk(2);
    pk(1'b1);
    rd(3'h0, 8'h0a);
    tk(1);
    rd(3'h0, 8'h0b);
    rd(3'h2, 8'h00);
    pk(1'b1);
    wr(3'h0, 8'h0b);
    wr(3'h1, 8'h31);
    wr(3'h6, 8'h01);
    tk(2);
    rd(3'h0, 8'h0a);
    rd(3'h2, 8'h00);
    pk(1'b0);
    wr(3'h4, 8'h01);
    wr(3'h6, 8'h00);
    for (int f = 0; f < 4; f++)
    begin
      wr(3'h0, 8'h03);
      wr(3'h1, {2'h0, f[1:0], ~f[1], 3'h0});
      wr(3'h0, 8'h08);
      pk(~f[1]);
      tk(1);
      pk(f != 1);
      rd(3'h2, 8'h01);
    end
    wr(3'h0, 8'h88);
    tk(3);
    rd(3'h2, 8'h01);
    wr(3'h0, 8'h08);
    tk(2);
    rd(3'h2, 8'h03);
    wr(3'h0, 8'h03);
    wr(3'h1, 8'hc0);
    wr(3'h0, 8'h08);
    tk(1);
    rd(3'h0, 8'h0a);
    chk({7'h00, pin_oe}, 8'h00);
    wr(3'h0, 8'h03);
    wr(3'h1, 8'ha8);
    wr(3'h6, 8'h04);
    wr(3'h0, 8'h08);
    pk(1'b1);
    r0 = rises;
    tk(8);
    pk(1'b1);
    chk(rises - r0, 8'h02);
    rd(3'h0, 8'h0b);
    wr(3'h4, 8'h04);
    r0 = rises;
    tk(8);
    chk(rises - r0, 8'h00);
    wr(3'h1, 8'hac);
    pk(1'b0);
    wr(3'h1, 8'h88);
    tk(2);
    pk(1'b0);
    rd(3'h2, 8'h02);
    report_and_stop;
  end
endmodule // ptmr_timer_bench
